/* hw/pio_pkg.sv */
// package for the two port units: register fields, reset values, carriers
// assumes one core clock and a synchronous active-low reset
package pio_pkg;

	// mode register and data latch reset values
	localparam logic [7:0] PIO_BIDIR_MODE_RST  = 8'hff;
	localparam logic [7:0] PIO_FIXED_MODE_RST  = 8'h00;
	localparam logic [7:0] PIO_PCFG_RST        = 8'h00;
	localparam logic [7:0] PIO_STOP_RCV_RST    = 8'h00;
	localparam logic [7:0] PIO_WDOG_RST        = 8'h00;
	localparam logic [7:0] PIO_DATA_RST        = 8'h00;
	localparam logic [3:0] PIO_FIXED_OUT_RST   = 4'h0;

	// fixed_port_mode_reg fields
	localparam int PIO_FM_PUSH_PULL = 0;
	localparam int PIO_FM_ANALOG    = 1;
	localparam int PIO_FM_HS_BIDIR  = 2;
	localparam int PIO_FM_HS_P0     = 3;
	localparam int PIO_FM_HS_P1     = 4;
	localparam int PIO_FM_TOUT_EN   = 5;

	// port_config_reg fields
	localparam int PIO_PC_CMP_OUT   = 0;
	localparam int PIO_PC_EMI_BIDIR = 1;
	localparam int PIO_PC_EMI_FIXED = 2;

	// bidir port line whose direction sets handshake direction
	localparam int PIO_HS_DIR_BIT   = 7;

	// edge select codes for input lines 1 and 2
	localparam logic [1:0] PIO_ES_FF = 2'b00;
	localparam logic [1:0] PIO_ES_FR = 2'b01;
	localparam logic [1:0] PIO_ES_RF = 2'b10;
	localparam logic [1:0] PIO_ES_BB = 2'b11;

	// request line numbers
	localparam int PIO_RQ_ZERO  = 0;
	localparam int PIO_RQ_ONE   = 1;
	localparam int PIO_RQ_TWO   = 2;
	localparam int PIO_RQ_THREE = 3;

	// mode register write carrier
	typedef struct packed {
		logic       bidir_we;
		logic       fixed_we;
		logic       pcfg_we;
		logic       stop_we;
		logic       wdog_we;
		logic [7:0] data;
	} pio_mode_wr_t;

	// held mode registers
	typedef struct packed {
		logic [7:0] bidir_port_mode_reg;
		logic [7:0] fixed_port_mode_reg;
		logic [7:0] port_config_reg;
		logic [7:0] stop_recovery_reg;
		logic [7:0] watchdog_mode_reg;
	} pio_modes_t;

	// handshake state of the bidirectional port
	typedef enum logic [1:0] {
		PIO_HS_IDLE = 2'b00,
		PIO_HS_LOAD = 2'b01,
		PIO_HS_SEND = 2'b10,
		PIO_HS_FULL = 2'b11
	} pio_hs_state_t;

endpackage : pio_pkg

/* hw/pio_edge_det.sv */
// two-stage synchroniser plus edge detector for a group of input lines
// assumes inputs may be asynchronous to clk_sys_i
`timescale 1ns/1ps
module pio_edge_det #(
	parameter int WIDTH = 4
) (
	// clock and reset
	input  wire logic             clk_sys_i,
	input  wire logic             rst_n_i,
	// raw lines
	input  wire logic [WIDTH-1:0] din_i,
	// synchronised level and one-cycle edges
	output logic      [WIDTH-1:0] lvl_o,
	output logic      [WIDTH-1:0] rise_o,
	output logic      [WIDTH-1:0] fall_o
);

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] sync_r;
	logic [WIDTH-1:0] prev_r;
	logic [2:0]       arm_r;

	// only sync_r looks at meta_r
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			meta_r <= '0;
			sync_r <= '0;
			prev_r <= '0;
			arm_r  <= '0;
		end else begin
			meta_r <= din_i;
			sync_r <= meta_r;
			prev_r <= sync_r;
			arm_r  <= {arm_r[1:0], 1'b1};
		end
	end

	// edges from settled stages, held off until both carry real levels
	assign lvl_o  = sync_r;
	assign rise_o = sync_r & ~prev_r & {WIDTH{arm_r[2]}};
	assign fall_o = ~sync_r & prev_r & {WIDTH{arm_r[2]}};

endmodule : pio_edge_det

/* hw/pio_port.sv */
// bidirectional 8-line port and fixed 4-in/4-out port with side functions
// assumes mode writes and data strobes come synchronous from the core
`timescale 1ns/1ps
module pio_port
	import pio_pkg::*;
(
	// clock and reset
	input  wire logic         clk_sys_i,
	input  wire logic         rst_n_i,
	// stop-mode recovery event
	input  wire logic         stop_rcv_i,
	// mode register writes and edge select
	input  wire pio_mode_wr_t mode_wr_i,
	input  wire logic [1:0]   edge_sel_i,
	// core data access
	input  wire logic         bidir_wr_i,
	input  wire logic [7:0]   bidir_wdata_i,
	input  wire logic         bidir_rd_i,
	input  wire logic         fixed_wr_i,
	input  wire logic [3:0]   fixed_wdata_i,
	// bidirectional port pins
	input  wire logic [7:0]   bidir_pin_i,
	output logic      [7:0]   bidir_pin_o,
	output logic      [7:0]   bidir_pin_oe_o,
	// fixed port pins: inputs lines 3..0, outputs lines 7..4
	input  wire logic [3:0]   fixed_pin_i,
	output logic      [3:0]   fixed_pin_o,
	// comparator macro
	input  wire logic [1:0]   cmp_result_i,
	output logic              cmp_en_o,
	// timer and other port handshake
	input  wire logic         tmr_out_i,
	output logic              tmr_in_o,
	input  wire logic         p0_hs_out_i,
	input  wire logic         p1_hs_out_i,
	output logic              p0_hs_in_o,
	output logic              p1_hs_in_o,
	// drive strength and status
	output logic              emi_bidir_o,
	output logic              emi_fixed_o,
	output logic      [3:0]   irq_o,
	output logic      [7:0]   bidir_rdata_o,
	output logic      [7:0]   fixed_rdata_o,
	output logic              hs_busy_o,
	output pio_modes_t        modes_o
);

	logic [7:0] bd_lvl;
	logic [3:0] fx_lvl;
	logic [3:0] fx_rise;
	logic [3:0] fx_fall;
	logic [1:0] cmp_lvl;
	logic [1:0] cmp_rise;
	logic [1:0] cmp_fall;

	// synchronisers for every port input
	pio_edge_det #(.WIDTH(8)) u_bidir_sync (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.din_i     (bidir_pin_i),
		.lvl_o     (bd_lvl),
		.rise_o    (),
		.fall_o    ()
	);
	pio_edge_det #(.WIDTH(4)) u_fixed_sync (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.din_i     (fixed_pin_i),
		.lvl_o     (fx_lvl),
		.rise_o    (fx_rise),
		.fall_o    (fx_fall)
	);
	pio_edge_det #(.WIDTH(2)) u_cmp_sync (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.din_i     (cmp_result_i),
		.lvl_o     (cmp_lvl),
		.rise_o    (cmp_rise),
		.fall_o    (cmp_fall)
	);

	// mode registers
	pio_modes_t modes_r;
	pio_modes_t modes_nxt;

	always_comb begin
		modes_nxt = modes_r;
		if (mode_wr_i.bidir_we)
			modes_nxt.bidir_port_mode_reg = mode_wr_i.data;
		if (mode_wr_i.fixed_we)
			modes_nxt.fixed_port_mode_reg = mode_wr_i.data;
		if (mode_wr_i.pcfg_we)
			modes_nxt.port_config_reg = mode_wr_i.data;
		if (mode_wr_i.stop_we)
			modes_nxt.stop_recovery_reg = mode_wr_i.data;
		if (mode_wr_i.wdog_we)
			modes_nxt.watchdog_mode_reg = mode_wr_i.data;
	end

	// only the reset reloads them, stop recovery leaves them alone
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			modes_r.bidir_port_mode_reg <= PIO_BIDIR_MODE_RST;
			modes_r.fixed_port_mode_reg <= PIO_FIXED_MODE_RST;
			modes_r.port_config_reg     <= PIO_PCFG_RST;
			modes_r.stop_recovery_reg   <= PIO_STOP_RCV_RST;
			modes_r.watchdog_mode_reg   <= PIO_WDOG_RST;
		end else begin
			modes_r <= modes_nxt;
		end
	end

	// decoded mode bits
	logic [7:0] fm;
	logic       analog;
	logic       hs_bd_en;
	logic       hs_dir_out;
	logic       cmp_route;
	assign fm         = modes_r.fixed_port_mode_reg;
	assign analog     = fm[PIO_FM_ANALOG];
	assign hs_bd_en   = fm[PIO_FM_HS_BIDIR];
	assign hs_dir_out = ~modes_r.bidir_port_mode_reg[PIO_HS_DIR_BIT];
	assign cmp_route  = analog & modes_r.port_config_reg[PIO_PC_CMP_OUT];

	// handshake state for the bidirectional port
	pio_hs_state_t hs_r;
	pio_hs_state_t hs_nxt;
	logic [7:0]    bd_out_r;
	logic [7:0]    bd_out_nxt;
	logic [7:0]    bd_cap_r;
	logic [7:0]    bd_cap_nxt;
	logic [3:0]    fx_out_r;
	logic [3:0]    fx_out_nxt;
	logic          hs_dav_in;
	logic          hs_rdy_in;

	// line 1 carries the far side's strobe in both directions
	assign hs_dav_in = fx_fall[1];
	assign hs_rdy_in = ~fx_lvl[1];

	always_comb begin
		hs_nxt     = hs_r;
		bd_out_nxt = bd_out_r;
		bd_cap_nxt = bd_cap_r;
		fx_out_nxt = fx_out_r;
		if (fixed_wr_i)
			fx_out_nxt = fixed_wdata_i;
		unique case (hs_r)
			PIO_HS_IDLE: begin
				if (bidir_wr_i)
					bd_out_nxt = bidir_wdata_i;
				if (hs_bd_en && hs_dir_out && bidir_wr_i)
					hs_nxt = PIO_HS_LOAD;
				else if (hs_bd_en && !hs_dir_out && hs_dav_in) begin
					bd_cap_nxt = bd_lvl;
					hs_nxt     = PIO_HS_FULL;
				end
			end
			PIO_HS_LOAD: begin
				hs_nxt = PIO_HS_SEND; // data settles a cycle first
			end
			PIO_HS_SEND: begin
				if (hs_rdy_in)
					hs_nxt = PIO_HS_IDLE;
			end
			PIO_HS_FULL: begin
				if (bidir_rd_i && fx_lvl[1])
					hs_nxt = PIO_HS_IDLE;
			end
		endcase
		if (stop_rcv_i || !hs_bd_en)
			hs_nxt = PIO_HS_IDLE;
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			hs_r     <= PIO_HS_IDLE;
			bd_out_r <= PIO_DATA_RST;
			bd_cap_r <= PIO_DATA_RST;
			fx_out_r <= PIO_FIXED_OUT_RST;
		end else begin
			hs_r     <= hs_nxt;
			bd_out_r <= bd_out_nxt;
			bd_cap_r <= bd_cap_nxt;
			fx_out_r <= fx_out_nxt;
		end
	end

	// pin, request and status next values
	logic [7:0] bd_pin_nxt;
	logic [7:0] bd_oe_nxt;
	logic [3:0] fx_pin_nxt;
	logic [3:0] irq_nxt;
	logic [7:0] bd_rd_nxt;
	logic [7:0] fx_rd_nxt;
	logic       rise_a;
	logic       fall_a;
	logic       rise_b;
	logic       fall_b;
	logic       hs_strobe;

	always_comb begin
		// output lines drive (open drain: only when low), input lines float
		bd_pin_nxt = bd_out_r;
		for (int i = 0; i < 8; i++) begin
			bd_oe_nxt[i] = ~modes_r.bidir_port_mode_reg[i] &
				(fm[PIO_FM_PUSH_PULL] | ~bd_out_r[i]);
		end
		// dav low while sending, ready low while full
		hs_strobe = ~((hs_r == PIO_HS_SEND) || (hs_r == PIO_HS_FULL));
		// fixed outputs, always driven push-pull
		fx_pin_nxt = fx_out_r;
		if (fm[PIO_FM_HS_P1])
			fx_pin_nxt[0] = p1_hs_out_i;
		if (cmp_route)
			fx_pin_nxt[0] = cmp_lvl[0];
		if (fm[PIO_FM_HS_P0])
			fx_pin_nxt[1] = p0_hs_out_i;
		if (fm[PIO_FM_TOUT_EN])
			fx_pin_nxt[2] = tmr_out_i;
		if (hs_bd_en)
			fx_pin_nxt[2] = hs_strobe;
		if (cmp_route)
			fx_pin_nxt[3] = cmp_lvl[1];
		// sources of lines 1 and 2 switch to comparators in analog mode
		rise_a = analog ? cmp_rise[0] : fx_rise[1];
		fall_a = analog ? cmp_fall[0] : fx_fall[1];
		rise_b = analog ? cmp_rise[1] : fx_rise[2];
		fall_b = analog ? cmp_fall[1] : fx_fall[2];
		irq_nxt = 4'h0;
		irq_nxt[PIO_RQ_THREE] = fx_fall[0];
		irq_nxt[PIO_RQ_ONE]   = fx_fall[3];
		unique case (edge_sel_i)
			PIO_ES_FF: begin
				irq_nxt[PIO_RQ_TWO]  = fall_a;
				irq_nxt[PIO_RQ_ZERO] = fall_b;
			end
			PIO_ES_FR: begin
				irq_nxt[PIO_RQ_TWO]  = fall_a;
				irq_nxt[PIO_RQ_ZERO] = rise_b;
			end
			PIO_ES_RF: begin
				irq_nxt[PIO_RQ_TWO]  = rise_a;
				irq_nxt[PIO_RQ_ZERO] = fall_b;
			end
			PIO_ES_BB: begin
				irq_nxt[PIO_RQ_TWO]  = rise_a | fall_a;
				irq_nxt[PIO_RQ_ZERO] = rise_b | fall_b;
			end
		endcase
		// read back: inputs from pins (captured byte in input handshake), outputs from latches
		for (int i = 0; i < 8; i++) begin
			bd_rd_nxt[i] = modes_r.bidir_port_mode_reg[i] ?
				bd_lvl[i] : bd_out_r[i];
		end
		if (hs_bd_en && !hs_dir_out)
			bd_rd_nxt = bd_cap_r;
		fx_rd_nxt = {fx_out_r, fx_lvl};
		if (analog)
			fx_rd_nxt[2:1] = cmp_lvl;
	end

	// every top output registered
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			bidir_pin_o    <= PIO_DATA_RST;
			bidir_pin_oe_o <= 8'h00;
			fixed_pin_o    <= PIO_FIXED_OUT_RST;
			cmp_en_o       <= 1'b0;
			tmr_in_o       <= 1'b0;
			p0_hs_in_o     <= 1'b0;
			p1_hs_in_o     <= 1'b0;
			emi_bidir_o    <= 1'b0;
			emi_fixed_o    <= 1'b0;
			irq_o          <= 4'h0;
			bidir_rdata_o  <= PIO_DATA_RST;
			fixed_rdata_o  <= PIO_DATA_RST;
			hs_busy_o      <= 1'b0;
			modes_o.bidir_port_mode_reg <= PIO_BIDIR_MODE_RST;
			modes_o.fixed_port_mode_reg <= PIO_FIXED_MODE_RST;
			modes_o.port_config_reg     <= PIO_PCFG_RST;
			modes_o.stop_recovery_reg   <= PIO_STOP_RCV_RST;
			modes_o.watchdog_mode_reg   <= PIO_WDOG_RST;
		end else begin
			bidir_pin_o    <= bd_pin_nxt;
			bidir_pin_oe_o <= bd_oe_nxt;
			fixed_pin_o    <= fx_pin_nxt;
			cmp_en_o       <= analog;
			tmr_in_o       <= fx_lvl[1];
			p0_hs_in_o     <= fx_lvl[2];
			p1_hs_in_o     <= fx_lvl[3];
			emi_bidir_o    <= modes_r.port_config_reg[PIO_PC_EMI_BIDIR];
			emi_fixed_o    <= modes_r.port_config_reg[PIO_PC_EMI_FIXED];
			irq_o          <= stop_rcv_i ? 4'h0 : irq_nxt;
			bidir_rdata_o  <= bd_rd_nxt;
			fixed_rdata_o  <= fx_rd_nxt;
			hs_busy_o      <= (hs_r != PIO_HS_IDLE);
			modes_o        <= modes_r;
		end
	end

endmodule : pio_port

/* verif/pio_periph_model.sv */
// peripheral beside the port: line resolution and handshake receiver
// assumes the core clock and the fixed port strobe line
`timescale 1ns/1ps
module pio_periph_model (
	// clock
	input  wire logic       clk_sys_i,
	// port drive and outside drive
	input  wire logic [7:0] dat_i,
	input  wire logic [7:0] oe_i,
	input  wire logic [7:0] ext_i,
	// handshake enable, strobe, answer delay
	input  wire logic       en_i,
	input  wire logic       stb_n_i,
	input  wire logic [2:0] lag_i,
	// line levels, captured byte, ready
	output logic      [7:0] lvl_o,
	output logic      [7:0] got_o,
	output logic            rdy_n_o
);
	logic [2:0] wait_r = 3'h0;
	initial begin
		rdy_n_o = 1'b1;
		got_o = 8'h00;
	end
	// port drive wins, else pull-up or outside drive
	assign lvl_o = (oe_i & dat_i) | (~oe_i & ext_i);
	// ready only after the byte is taken
	always @(posedge clk_sys_i) begin
		if (!en_i || stb_n_i) begin
			wait_r <= 3'h0;
			rdy_n_o <= 1'b1;
		end else if (rdy_n_o && wait_r == lag_i) begin
			got_o <= lvl_o;
			rdy_n_o <= 1'b0;
		end else if (rdy_n_o) begin
			wait_r <= wait_r + 3'h1;
		end
	end
endmodule : pio_periph_model

/* verif/pio_port_monitor.sv */
// checker for the port unit, bound to its top module
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module pio_port_monitor
	import pio_pkg::*;
(
	// clock and reset
	input wire logic         clk_sys_i,
	input wire logic         rst_n_i,
	// watched inputs
	input wire logic         stop_rcv_i,
	input wire pio_mode_wr_t mode_wr_i,
	input wire logic [1:0]   edge_sel_i,
	input wire logic [3:0]   fixed_pin_i,
	input wire logic [1:0]   cmp_result_i,
	// watched outputs
	input wire logic [7:0]   bidir_pin_o,
	input wire logic [7:0]   bidir_pin_oe_o,
	input wire logic [3:0]   fixed_pin_o,
	input wire logic         cmp_en_o,
	input wire logic         tmr_in_o,
	input wire logic [3:0]   irq_o,
	input wire logic         hs_busy_o,
	input wire pio_modes_t   modes_o
);
	logic [2:0] rc_r;
	logic [2:0] rc_nxt;
	logic [7:0] dir;
	logic       pp;
	logic       we_any;
	// cycles since reset, synchronisers settle meanwhile
	always_comb begin
		rc_nxt = !rst_n_i ? 3'h0 : (rc_r == 3'h7) ? rc_r : rc_r + 3'h1;
	end
	always_ff @(posedge clk_sys_i) begin
		rc_r <= rc_nxt;
	end
	assign dir = modes_o.bidir_port_mode_reg;
	assign pp = modes_o.fixed_port_mode_reg[PIO_FM_PUSH_PULL];
	assign we_any = |mode_wr_i[12:8];
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);
	property p_dir;
		(bidir_pin_oe_o & dir & $past(dir)) == 8'h00;
	endproperty
	a_dir: assert property (p_dir)
		else $error("input line driven");
	property p_od;
		!pp && $stable(pp) && $stable(bidir_pin_o) && $stable(bidir_pin_oe_o)
			|-> (bidir_pin_oe_o & bidir_pin_o) == 8'h00;
	endproperty
	a_od: assert property (p_od)
		else $error("open drain drove high");
	property p_fall3;
		rc_r[2] && $fell(fixed_pin_i[0]) && !stop_rcv_i |-> ##[2:6] irq_o[3];
	endproperty
	a_fall3: assert property (p_fall3)
		else $error("line 0 fall lost");
	property p_once;
		irq_o != 4'h0 |=> (irq_o & $past(irq_o)) == 4'h0;
	endproperty
	a_once: assert property (p_once)
		else $error("request longer than one cycle");
	property p_rise1;
		rc_r[2] && $rose(fixed_pin_i[1]) && edge_sel_i[1] && !cmp_en_o
			|-> ##[2:6] irq_o[2];
	endproperty
	a_rise1: assert property (p_rise1)
		else $error("line 1 rise lost");
	property p_route;
		(cmp_en_o && modes_o.port_config_reg[PIO_PC_CMP_OUT]
			&& $stable(cmp_result_i)) [*4]
			|-> {fixed_pin_o[3], fixed_pin_o[0]} == cmp_result_i;
	endproperty
	a_route: assert property (p_route)
		else $error("comparator route wrong");
	property p_stop;
		stop_rcv_i && !we_any && !$past(we_any) |=> modes_o == $past(modes_o);
	endproperty
	a_stop: assert property (p_stop)
		else $error("modes lost on stop recovery");
	property p_hold;
		hs_busy_o && !fixed_pin_o[2] |-> $stable(bidir_pin_o);
	endproperty
	a_hold: assert property (p_hold)
		else $error("data moved under strobe");
	property p_tmr;
		(rc_r[2] && $stable(fixed_pin_i[1])) [*4]
			|-> tmr_in_o == fixed_pin_i[1];
	endproperty
	a_tmr: assert property (p_tmr)
		else $error("timer input wrong");
endmodule : pio_port_monitor
bind pio_port pio_port_monitor u_mon (
	.clk_sys_i, .rst_n_i, .stop_rcv_i, .mode_wr_i, .edge_sel_i,
	.fixed_pin_i, .cmp_result_i, .bidir_pin_o, .bidir_pin_oe_o,
	.fixed_pin_o, .cmp_en_o, .tmr_in_o, .irq_o, .hs_busy_o, .modes_o
);

/* verif/testbench.sv */
// bench for the port unit: modes, pins, requests, handshake
// assumes the peripheral model and checker compile first
`timescale 1ns/1ps
module testbench
	import pio_pkg::*;
;
	logic         clk_sys_i = 1'b0;
	logic         rst_n_i = 1'b0;
	logic         stop_rcv_i = 1'b0;
	pio_mode_wr_t mode_wr_i = '0;
	logic [1:0]   edge_sel_i = 2'h0;
	logic         bidir_wr_i = 1'b0;
	logic [7:0]   bidir_wdata_i = 8'h00;
	logic         bidir_rd_i = 1'b0;
	logic         fixed_wr_i = 1'b0;
	logic [3:0]   fixed_wdata_i = 4'h0;
	logic [1:0]   cmp_result_i = 2'h0;
	logic [2:0]   side_i = 3'h0;
	logic [3:0]   fp = 4'hf;
	logic         hs_en = 1'b0;
	logic [2:0]   lag = 3'h0;
	logic [7:0]   bidir_pin_i, bidir_pin_o, bidir_pin_oe_o, got, cnts;
	logic [3:0]   fixed_pin_i, fixed_pin_o, irq_o;
	logic         cmp_en_o, tmr_in_o, p0_hs_in_o, p1_hs_in_o, rdy_n;
	logic         emi_bidir_o, emi_fixed_o, hs_busy_o;
	pio_modes_t   modes_o;
	logic [39:0]  sh;
	logic [1:0]   cnt [4];
	logic         cnt_clr = 1'b0;
	logic [7:0]   rd_b, rd_f;
	logic [7:0]   ext = 8'hff;
	int           seed = 2;
	int           fail_count = 0;
	int           samples_checked = 0;
	int           cyc = 0;
	pio_port dut (
		.clk_sys_i, .rst_n_i, .stop_rcv_i, .mode_wr_i, .edge_sel_i,
		.bidir_wr_i, .bidir_wdata_i, .bidir_rd_i, .fixed_wr_i,
		.fixed_wdata_i, .bidir_pin_i, .bidir_pin_o, .bidir_pin_oe_o,
		.fixed_pin_i, .fixed_pin_o, .cmp_result_i, .cmp_en_o,
		.tmr_out_i(side_i[2]), .tmr_in_o, .p0_hs_out_i(side_i[1]),
		.p1_hs_out_i(side_i[0]), .p0_hs_in_o, .p1_hs_in_o, .emi_bidir_o,
		.emi_fixed_o, .irq_o, .bidir_rdata_o(rd_b), .fixed_rdata_o(rd_f),
		.hs_busy_o, .modes_o
	);
	pio_periph_model peer (
		.clk_sys_i, .dat_i(bidir_pin_o), .oe_i(bidir_pin_oe_o),
		.ext_i(ext), .en_i(hs_en), .stb_n_i(fixed_pin_o[2]),
		.lag_i(lag), .lvl_o(bidir_pin_i), .got_o(got), .rdy_n_o(rdy_n)
	);
	// ready from the peripheral replaces line 1 in handshake
	assign fixed_pin_i = {fp[3:2], hs_en ? rdy_n : fp[1], fp[0]};
	assign cnts = {cnt[3], cnt[2], cnt[1], cnt[0]};
	always #12.5 clk_sys_i = ~clk_sys_i;
	// count request pulses, cut a hang short
	always @(posedge clk_sys_i) begin
		for (int i = 0; i < 4; i++) begin
			cnt[i] <= cnt_clr ? 2'h0 : cnt[i] + 2'(irq_o[i]);
		end
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fail_count++;
			stop_test();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
		#2;
	endtask : tick
	task automatic chk(input string nm, input logic [39:0] v, e);
		samples_checked++;
		if (v !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, v);
		end
	endtask : chk
	task automatic wm(input int k, input logic [7:0] d);
		mode_wr_i = {5'(1 << k), d};
		sh[8*k +: 8] = d;
		tick(1);
		mode_wr_i = '0;
		tick(3);
		chk("modes", modes_o, sh);
	endtask : wm
	task automatic wb(input logic [7:0] d);
		bidir_wdata_i = d;
		bidir_wr_i = 1'b1;
		tick(1);
		bidir_wr_i = 1'b0;
		tick(3);
	endtask : wb
	task automatic clr_cnt;
		cnt_clr = 1'b1;
		tick(1);
		cnt_clr = 1'b0;
	endtask : clr_cnt
	task automatic stop_test;
		if (fail_count == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : stop_test
	function automatic logic [7:0] exp_oe(input logic [7:0] m, d,
		input logic p);
		return ~m & (p ? 8'hff : ~d);
	endfunction : exp_oe
	// pulse counts {rq3, rq2, rq1, rq0} after all lines move
	function automatic logic [7:0] exp_irq(input logic [1:0] s,
		input logic f);
		if (f) return {2'h1, 1'b0, s != 2'b10, 2'h1, 1'b0, s != 2'b01};
		return {2'h0, 1'b0, s[1], 2'h0, 1'b0, s[0]};
	endfunction : exp_irq
	initial begin
		logic [7:0] m;
		logic [7:0] d;
		int n;
		sh = {PIO_BIDIR_MODE_RST, PIO_FIXED_MODE_RST, PIO_PCFG_RST,
			PIO_STOP_RCV_RST, PIO_WDOG_RST};
		tick(20);
		chk("reset modes", modes_o, sh);
		chk("reset oe", bidir_pin_oe_o, 8'h00);
		rst_n_i = 1'b1;
		tick(4);
		// random directions, data and drive type
		repeat (8) begin
			m = $random(seed);
			d = $random(seed);
			n = $random(seed);
			wm(3, 8'(n & 1));
			wm(4, m);
			wb(d);
			chk("oe", bidir_pin_oe_o, exp_oe(m, d, n[0]));
			chk("pins", bidir_pin_i, d | m);
			chk("read back", rd_b, d | m);
		end
		// drive selects and fixed outputs
		for (int i = 0; i < 4; i++) begin
			wm(2, 8'(i << 1));
			chk("emi", {emi_bidir_o, emi_fixed_o}, {i[0], i[1]});
			fixed_wdata_i = 4'($random(seed));
			fixed_wr_i = 1'b1;
			tick(1);
			fixed_wr_i = 1'b0;
			tick(3);
			chk("fixed out", fixed_pin_o, fixed_wdata_i);
		end
		// every edge code, all lines fall then rise
		for (int s = 0; s < 4; s++) begin
			edge_sel_i = 2'(s);
			for (int f = 1; f >= 0; f--) begin
				clr_cnt();
				fp = f[0] ? 4'h0 : 4'hf;
				tick(8);
				d = exp_irq(2'(s), f[0]);
				chk("events", cnts, d);
			end
		end
		// timer and other-port handshake lines
		wm(3, 8'h39);
		repeat (4) begin
			side_i = 3'($random(seed));
			fp = 4'($random(seed));
			tick(6);
			d = {2'h0, fp[1], fp[2], fp[3], side_i};
			m = {2'h0, tmr_in_o, p0_hs_in_o, p1_hs_in_o, fixed_pin_o[2:0]};
			chk("side", m, d);
		end
		// comparators on, routed out, raising requests
		wm(2, 8'h01);
		wm(3, 8'h03);
		chk("cmp on", cmp_en_o, 1'b1);
		edge_sel_i = PIO_ES_BB;
		for (int i = 0; i < 4; i++) begin
			clr_cnt();
			cmp_result_i = 2'(8'h2d >> (2 * i));
			tick(8);
			chk("cmp req", cnts, i[0] ? 8'h01 : 8'h10);
			chk("cmp out", {fixed_pin_o[3], fixed_pin_o[0]}, cmp_result_i);
			d = {fixed_wdata_i, fp[3], cmp_result_i, fp[0]};
			chk("cmp read", rd_f, d);
		end
		wm(3, 8'h01);
		chk("cmp off", cmp_en_o, 1'b0);
		// output handshake, prompt then slow peripheral
		wm(4, 8'h00);
		wm(3, 8'h05);
		hs_en = 1'b1;
		for (int i = 0; i < 2; i++) begin
			lag = 3'(5 * i);
			d = $random(seed);
			wb(d);
			n = 0;
			while (hs_busy_o !== 1'b0 && n < 40) begin
				tick(1);
				n++;
			end
			tick(3);
			chk("hs data", got, d);
			chk("hs strobe", {hs_busy_o, fixed_pin_o[2]}, 2'b01);
		end
		// input handshake, byte taken on line 1 falling
		fp = 4'hf;
		hs_en = 1'b0;
		ext = 8'($random(seed));
		wm(4, 8'hff);
		fp[1] = 1'b0;
		tick(6);
		chk("hs in data", rd_b, ext);
		chk("hs in full", {hs_busy_o, fixed_pin_o[2]}, 2'b10);
		fp[1] = 1'b1;
		tick(4);
		bidir_rd_i = 1'b1;
		tick(1);
		bidir_rd_i = 1'b0;
		tick(3);
		chk("hs in idle", {hs_busy_o, fixed_pin_o[2]}, 2'b01);
		// stop recovery keeps every mode register
		wm(0, 8'($random(seed)));
		wm(1, 8'($random(seed)));
		stop_rcv_i = 1'b1;
		tick(1);
		stop_rcv_i = 1'b0;
		tick(2);
		chk("stop keep", modes_o, sh);
		stop_test();
	end
endmodule : testbench
